// >>> hw/mas_pkg.sv
package mas_pkg;

    localparam int unsigned LANE9_W = 9;
    localparam int unsigned LANE18_W = 18;
    localparam int unsigned N9 = 8;
    localparam int unsigned N18 = 4;
    localparam int unsigned OP_W = 72;
    localparam int unsigned RES_W = 144;
    localparam int unsigned ACC_W = 52;
    localparam int unsigned EXT_W = 38;
    localparam int unsigned SLOT9_W = 36;
    localparam int unsigned SLOT18_W = 72;
    localparam int unsigned FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        MAS_MULT,
        MAS_MAC,
        MAS_ADD2,
        MAS_ADD4
    } mas_mode_t;

    typedef enum logic [1:0] {
        MAS_W9,
        MAS_W18,
        MAS_W36,
        MAS_WBAD
    } mas_width_t;

    typedef struct packed {
        mas_mode_t mode;
        mas_width_t width;
        logic signed_ops;
        logic [3:0] sub;
        logic [1:0] acc_sub;
        logic acc_clr;
        logic casc_en;
    } mas_cfg_t;

    typedef struct packed {
        mas_mode_t mode;
        mas_width_t width;
        logic err;
        logic [RES_W-1:0] data;
    } mas_res_t;

    localparam int unsigned RES_T_W = $bits(mas_res_t);
    localparam logic [OP_W-1:0] OP_RST = 72'h00_0000_0000_0000_0000;
    localparam logic [ACC_W-1:0] ACC_RST = 52'h0_0000_0000_0000;
    localparam logic [EXT_W-1:0] CASC_RST = 38'h00_0000_0000;
    localparam mas_cfg_t CFG_RST = '0;

endpackage

// >>> hw/mas_fifo.sv
`timescale 1ns/1ps
module mas_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign wr_ready = (count_q != (AW+1)'(DEPTH));
    assign rd_valid = (count_q != '0);
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;
    assign rd_data = mem_q[rptr_q];

    // Storage has no reset; rd_data is only meaningful while rd_valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wptr_q] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
        count_q <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");

endmodule

// >>> hw/mas_slice.sv
`timescale 1ns/1ps
module mas_slice #(
    parameter int unsigned FIFO_DEPTH = mas_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ena,
    input wire logic in_valid,
    output logic in_ready,
    input wire mas_pkg::mas_cfg_t cfg,
    input wire logic [mas_pkg::OP_W-1:0] a_in,
    input wire logic [mas_pkg::OP_W-1:0] b_in,
    input wire logic shift_a,
    input wire logic coef_serial,
    input wire logic coef_hold,
    input wire logic [mas_pkg::LANE18_W-1:0] scan_a_in,
    output logic [mas_pkg::LANE18_W-1:0] scan_a_out,
    input wire logic [mas_pkg::LANE18_W-1:0] scan_b_in,
    output logic [mas_pkg::LANE18_W-1:0] scan_b_out,
    input wire logic [mas_pkg::EXT_W-1:0] casc_in,
    output logic [mas_pkg::EXT_W-1:0] casc_out,
    output logic out_valid,
    input wire logic out_ready,
    output mas_pkg::mas_res_t out_res
);
    localparam int unsigned EW = mas_pkg::EXT_W;
    localparam int unsigned AW = mas_pkg::ACC_W;

    logic [mas_pkg::OP_W-1:0] a_q;
    logic [mas_pkg::OP_W-1:0] b_q;
    mas_pkg::mas_cfg_t cfg_q;
    logic v1_q;
    logic [AW-1:0] acc_q [2];
    logic [AW-1:0] acc_d [2];
    logic [EW-1:0] casc_q;
    logic fifo_ready;
    logic advance;
    logic take;
    logic push;
    logic s;
    logic signed [19:0] m9 [8];
    logic signed [37:0] m18 [4];
    logic signed [73:0] m36;
    logic [EW-1:0] pe9 [8];
    logic [EW-1:0] pe18 [4];
    logic [EW-1:0] u [4];
    logic [EW-1:0] s4 [2];
    logic err;
    mas_pkg::mas_res_t wr_res;

    // A full result queue freezes the whole slice, so no sum is ever dropped
    assign advance = !v1_q || fifo_ready;
    assign in_ready = ena && advance;
    assign take = in_valid && in_ready;
    assign push = v1_q && fifo_ready;
    assign s = cfg_q.signed_ops;

    // Operand and chain registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_q <= mas_pkg::OP_RST;
        end else if (take) begin
            if (shift_a) begin
                a_q <= {a_q[53:0], scan_a_in};
            end else begin
                a_q <= a_in;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            b_q <= mas_pkg::OP_RST;
        end else if (take && !coef_hold) begin
            if (coef_serial) begin
                b_q <= {b_q[53:0], scan_b_in};
            end else begin
                b_q <= b_in;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= mas_pkg::CFG_RST;
            v1_q <= 1'b0;
        end else if (advance) begin
            v1_q <= take;
            if (take) begin
                cfg_q <= cfg;
            end
        end
    end

    // Chain taps leave the slice toward the next slice or column
    assign scan_a_out = a_q[71:54];
    assign scan_b_out = b_q[71:54];

    // One sign control for both operands; mixed signedness is not offered
    for (genvar i = 0; i < 8; i++) begin : g_m9
        assign m9[i] = $signed({s & a_q[9*i+8], a_q[9*i+:9]})
                     * $signed({s & b_q[9*i+8], b_q[9*i+:9]});
        assign pe9[i] = {{20{s & m9[i][17]}}, m9[i][17:0]};
    end

    for (genvar j = 0; j < 4; j++) begin : g_m18
        assign m18[j] = $signed({s & a_q[18*j+17], a_q[18*j+:18]})
                      * $signed({s & b_q[18*j+17], b_q[18*j+:18]});
        assign pe18[j] = {{2{s & m18[j][35]}}, m18[j][35:0]};
    end

    assign m36 = $signed({s & a_q[35], a_q[35:0]})
               * $signed({s & b_q[35], b_q[35:0]});

    // First-stage adder/subtractor units; four at 9 bits, two at 18 bits
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            u[k] = '0;
        end
        if (cfg_q.width == mas_pkg::MAS_W9) begin
            for (int k = 0; k < 4; k++) begin
                u[k] = cfg_q.sub[k] ? pe9[2*k] - pe9[2*k+1]
                                    : pe9[2*k] + pe9[2*k+1];
            end
        end else if (cfg_q.width == mas_pkg::MAS_W18) begin
            for (int k = 0; k < 2; k++) begin
                u[k] = cfg_q.sub[k] ? pe18[2*k] - pe18[2*k+1]
                                    : pe18[2*k] + pe18[2*k+1];
            end
        end
    end

    // Second stage; the cascade term lets fabric chain longer filters
    always_comb begin
        s4[0] = u[0] + u[1];
        s4[1] = u[2] + u[3];
        if (cfg_q.width == mas_pkg::MAS_W18) begin
            s4[1] = '0;
            if (cfg_q.casc_en) begin
                s4[0] = u[0] + u[1] + casc_in;
            end
        end
    end

    // 36-bit products have no adder behind them; other modes flag an error
    assign err = (cfg_q.width == mas_pkg::MAS_WBAD)
              || (cfg_q.width == mas_pkg::MAS_W36
                  && cfg_q.mode != mas_pkg::MAS_MULT);

    always_comb begin
        logic [EW-1:0] p;
        p = '0;
        for (int c = 0; c < 2; c++) begin
            acc_d[c] = acc_q[c];
        end
        if (cfg_q.mode == mas_pkg::MAS_MAC && !err) begin
            for (int c = 0; c < 2; c++) begin
                p = (cfg_q.width == mas_pkg::MAS_W9) ? pe9[4*c] : pe18[2*c];
                acc_d[c] = cfg_q.acc_sub[c]
                         ? (cfg_q.acc_clr ? '0 : acc_q[c]) - {{14{p[EW-1]}}, p}
                         : (cfg_q.acc_clr ? '0 : acc_q[c]) + {{14{p[EW-1]}}, p};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q[0] <= mas_pkg::ACC_RST;
            acc_q[1] <= mas_pkg::ACC_RST;
        end else if (push) begin
            acc_q[0] <= acc_d[0];
            acc_q[1] <= acc_d[1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            casc_q <= mas_pkg::CASC_RST;
        end else if (push && cfg_q.mode == mas_pkg::MAS_ADD4 && !err) begin
            casc_q <= s4[0];
        end
    end
    assign casc_out = casc_q;

    // Result packing; wider sums are sign extended into their slots
    always_comb begin
        wr_res = '0;
        wr_res.mode = cfg_q.mode;
        wr_res.width = cfg_q.width;
        wr_res.err = err;
        if (!err) begin
            unique case (cfg_q.mode)
                mas_pkg::MAS_MULT: begin
                    if (cfg_q.width == mas_pkg::MAS_W9) begin
                        for (int i = 0; i < 8; i++) begin
                            wr_res.data[18*i+:18] = m9[i][17:0];
                        end
                    end else if (cfg_q.width == mas_pkg::MAS_W18) begin
                        for (int j = 0; j < 4; j++) begin
                            wr_res.data[36*j+:36] = m18[j][35:0];
                        end
                    end else begin
                        wr_res.data[71:0] = m36[71:0];
                    end
                end
                mas_pkg::MAS_MAC: begin
                    wr_res.data[51:0] = acc_d[0];
                    wr_res.data[103:52] = acc_d[1];
                end
                mas_pkg::MAS_ADD2: begin
                    if (cfg_q.width == mas_pkg::MAS_W9) begin
                        for (int k = 0; k < 4; k++) begin
                            wr_res.data[36*k+:36] = u[k][35:0];
                        end
                    end else begin
                        for (int k = 0; k < 2; k++) begin
                            wr_res.data[72*k+:72] = {{34{u[k][EW-1]}}, u[k]};
                        end
                    end
                end
                mas_pkg::MAS_ADD4: begin
                    for (int k = 0; k < 2; k++) begin
                        wr_res.data[72*k+:72] = {{34{s4[k][EW-1]}}, s4[k]};
                    end
                end
            endcase
        end
    end

    mas_fifo #(
        .WIDTH(mas_pkg::RES_T_W),
        .DEPTH(FIFO_DEPTH)
    ) u_mas_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .wr_valid(v1_q),
        .wr_ready(fifo_ready),
        .wr_data(wr_res),
        .rd_valid(out_valid),
        .rd_ready(out_ready),
        .rd_data(out_res)
    );

    a_real_sub: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_ADD2 && cfg_q.width == mas_pkg::MAS_W18
        && cfg_q.sub[0] |-> wr_res.data[EW-1:0] == EW'(pe18[0] - pe18[1]))
        else $error("real part is not a difference");

    a_dual_cplx: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_ADD2 && cfg_q.width == mas_pkg::MAS_W9
        && !cfg_q.sub[3] |-> wr_res.data[143:108] == 36'(pe9[6] + pe9[7]))
        else $error("fourth nine-bit unit lost");

    a_stage_two: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_ADD4 && cfg_q.width == mas_pkg::MAS_W18
        |=> casc_out == $past(u[0]) + $past(u[1])
            + ($past(cfg_q.casc_en) ? $past(casc_in) : '0))
        else $error("second stage sum wrong");

    a_coef_shift: assert property (@(posedge clk) disable iff (!rst_n)
        take && coef_serial && !coef_hold
        |=> b_q[17:0] == $past(scan_b_in) && b_q[35:18] == $past(b_q[17:0]))
        else $error("coefficient chain did not shift");

    a_chain_out: assert property (@(posedge clk) disable iff (!rst_n)
        take && shift_a |=> scan_a_out == $past(a_q[53:36]))
        else $error("data chain tap wrong");

    a_mac_no36: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_MAC && cfg_q.width == mas_pkg::MAS_W36
        |-> wr_res.err ##1 acc_q[0] == $past(acc_q[0]))
        else $error("accumulator moved at 36 bits");

    a_acc_step: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_MAC && cfg_q.width == mas_pkg::MAS_W18
        && !cfg_q.acc_clr && !cfg_q.acc_sub[1]
        |=> acc_q[1] == $past(acc_q[1]) + {{14{$past(pe18[2][EW-1])}}, $past(pe18[2])})
        else $error("accumulator step wrong");

    a_mult_top: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_MULT && cfg_q.width == mas_pkg::MAS_W36
        |-> wr_res.data[143:72] == '0 && !wr_res.err)
        else $error("36-bit product spilled");

    a_enable_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !ena |-> !in_ready ##1 (a_q == $past(a_q) && b_q == $past(b_q)))
        else $error("storage moved while disabled");

    a_acc_load: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_MAC && cfg_q.width == mas_pkg::MAS_W9
        && cfg_q.acc_clr && !cfg_q.acc_sub[0]
        |=> $signed(acc_q[0]) == $signed($past(pe9[0])))
        else $error("accumulator restart wrong");

    a_nine_sum2: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_ADD4 && cfg_q.width == mas_pkg::MAS_W9
        |-> $signed(wr_res.data[143:72]) == $signed(EW'(u[2] + u[3])))
        else $error("second nine-bit sum wrong");

    a_casc_off: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_ADD4 && cfg_q.width == mas_pkg::MAS_W18
        && !cfg_q.casc_en |-> wr_res.data[EW-1:0] == EW'(u[0] + u[1]))
        else $error("cascade input leaked");

    a_one_sum18: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_ADD4 && cfg_q.width == mas_pkg::MAS_W18
        |-> wr_res.data[143:72] == '0)
        else $error("second sum present at 18 bits");

    a_lane_unsigned: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_MULT && cfg_q.width == mas_pkg::MAS_W9 && !s
        |-> wr_res.data[17:0] == {9'h000, a_q[8:0]} * {9'h000, b_q[8:0]})
        else $error("unsigned nine-bit product wrong");

    a_lane_signed: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode == mas_pkg::MAS_MULT && cfg_q.width == mas_pkg::MAS_W18 && s
        |-> $signed(wr_res.data[35:0]) == $signed(a_q[17:0]) * $signed(b_q[17:0]))
        else $error("signed 18-bit product wrong");

    a_err_zero: assert property (@(posedge clk) disable iff (!rst_n)
        push && err |-> wr_res.data == '0)
        else $error("refused word carries data");

    a_acc_idle: assert property (@(posedge clk) disable iff (!rst_n)
        push && cfg_q.mode != mas_pkg::MAS_MAC
        |=> acc_q[0] == $past(acc_q[0]) && acc_q[1] == $past(acc_q[1]))
        else $error("accumulator moved outside its mode");

endmodule

// >>> tb/mas_fabric_sink.sv
`timescale 1ns/1ps
module mas_fabric_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic out_valid,
    input wire mas_pkg::mas_res_t out_res,
    output logic out_ready
);
    mas_pkg::mas_res_t got_q[$];
    // Ready is registered, so a stall takes effect one edge late, like real fabric
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !stall;
            if (out_valid === 1'b1 && out_ready) begin
                got_q.push_back(out_res);
            end
        end
    end
endmodule

// >>> tb/tb_mas_slice.sv
`timescale 1ns/1ps
module tb_mas_slice;
    localparam logic [71:0] A0 = 72'hf3_a5c7_1e92_b46d_8075;
    localparam logic [71:0] B0 = 72'h9c_6e21_d4f8_37a0_5cb9;
    localparam logic [71:0] A1 = 72'h2b_e019_7fd3_c68a_41f6;
    localparam logic [143:0] FULL = {144{1'b1}};
    localparam logic [143:0] M72 = {{72{1'b0}}, {72{1'b1}}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ena = 1'b1;
    logic in_valid = 1'b0;
    logic shift_a = 1'b0;
    logic coef_serial = 1'b0;
    logic coef_hold = 1'b0;
    logic stall = 1'b0;
    mas_pkg::mas_cfg_t cfg = mas_pkg::CFG_RST;
    logic [71:0] a_in = '0;
    logic [71:0] b_in = '0;
    logic [17:0] scan_a_in = '0;
    logic [17:0] scan_b_in = '0;
    logic [37:0] casc_in = '0;
    logic [17:0] scan_a_out;
    logic [17:0] scan_b_out;
    logic [37:0] casc_out;
    logic in_ready;
    logic out_valid;
    logic out_ready;
    mas_pkg::mas_res_t out_res;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;

    mas_slice #(.FIFO_DEPTH(mas_pkg::FIFO_DEPTH)) u_mas_slice (.clk(clk), .rst_n(rst_n),
        .ena(ena), .in_valid(in_valid), .in_ready(in_ready), .cfg(cfg), .a_in(a_in),
        .b_in(b_in), .shift_a(shift_a), .coef_serial(coef_serial), .coef_hold(coef_hold),
        .scan_a_in(scan_a_in), .scan_a_out(scan_a_out), .scan_b_in(scan_b_in),
        .scan_b_out(scan_b_out), .casc_in(casc_in), .casc_out(casc_out),
        .out_valid(out_valid), .out_ready(out_ready), .out_res(out_res));
    mas_fabric_sink u_mas_fabric_sink (.clk(clk), .rst_n(rst_n), .stall(stall),
        .out_valid(out_valid), .out_res(out_res), .out_ready(out_ready));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic results();
        $display("counts: %0d compared, %0d wrong", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard: whole run is under two hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end

    task automatic chk(input logic [159:0] seen, input logic [159:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    function automatic logic [143:0] ext(input logic [143:0] v, input int w, input logic s);
        logic [143:0] m;
        m = (144'h1 << w) - 144'h1;
        v = v & m;
        if (s && v[w-1]) v = v | ~m;
        return v;
    endfunction

    function automatic logic [143:0] mul(input logic [71:0] x, input logic [71:0] y,
        input int w, input int i, input logic s);
        return ext(x >> (w * i), w, s) * ext(y >> (w * i), w, s);
    endfunction

    function automatic logic [143:0] un(input logic [71:0] x, input logic [71:0] y,
        input int w, input int k, input logic s, input logic sb);
        if (sb) return mul(x, y, w, 2 * k, s) - mul(x, y, w, 2 * k + 1, s);
        return mul(x, y, w, 2 * k, s) + mul(x, y, w, 2 * k + 1, s);
    endfunction

    // One width for every lane, so all products of a sum match in size
    function automatic mas_pkg::mas_cfg_t mk(input mas_pkg::mas_mode_t md,
        input mas_pkg::mas_width_t wd, input logic s, input logic [3:0] sb);
        mas_pkg::mas_cfg_t c;
        c = mas_pkg::CFG_RST;
        c.mode = md;
        c.width = wd;
        c.signed_ops = s;
        c.sub = sb;
        return c;
    endfunction

    // Called right after a rising edge; returns at the edge that takes the word
    task automatic send(input mas_pkg::mas_cfg_t c, input logic [71:0] a, input logic [71:0] b);
        int n;
        cfg <= c;
        a_in <= a;
        b_in <= b;
        in_valid <= 1'b1;
        n = 0;
        @(negedge clk);
        while (in_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n == 50) chk(0, 1, "intake stuck");
        @(posedge clk);
    endtask

    task automatic get_chk(input mas_pkg::mas_cfg_t c, input logic er, input logic [143:0] e,
        input logic [143:0] m, input string what);
        int n;
        mas_pkg::mas_res_t r;
        n = 0;
        in_valid <= 1'b0;
        while (u_mas_fabric_sink.got_q.size() == 0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        r = '0;
        if (n < 100) r = u_mas_fabric_sink.got_q.pop_front();
        if (n == 100) chk(0, 1, "no result arrived");
        chk({r.mode, r.width, r.err, r.data & m}, {c.mode, c.width, er, e & m}, what);
    endtask

    task automatic one(input mas_pkg::mas_cfg_t c, input logic [71:0] a, input logic [71:0] b,
        input logic [143:0] e, input logic [143:0] m, input string what);
        send(c, a, b);
        get_chk(c, 1'b0, e, m, what);
    endtask

    task automatic t_mult();
        int lw;
        logic [143:0] e;
        for (int w = 0; w < 3; w++) begin
            for (int s = 0; s < 2; s++) begin
                lw = (w == 0) ? 9 : (w == 1) ? 18 : 36;
                e = '0;
                for (int i = 0; i < 72 / lw; i++) begin
                    e = e | (ext(mul(A0, B0, lw, i, s[0]), 2 * lw, 1'b0) << (2 * lw * i));
                end
                one(mk(mas_pkg::MAS_MULT, mas_pkg::mas_width_t'(w), s[0], 4'h0), A0, B0, e,
                    (w == 2) ? M72 : FULL, "plain products");
            end
        end
        $display("plain multiplier test done");
    endtask

    task automatic t_add2();
        longint ra;
        longint ia;
        logic [143:0] e;
        // Complex (-5 + j291) x (-131072 + j131071)
        ra = (-64'sd5) * (-64'sd131072) - 64'sd291 * 64'sd131071;
        ia = (-64'sd5) * 64'sd131071 + 64'sd291 * (-64'sd131072);
        e = {ext(144'(ia), 64, 1'b1), 72'h0} | ext(144'(ra), 64, 1'b1) & M72;
        one(mk(mas_pkg::MAS_ADD2, mas_pkg::MAS_W18, 1'b1, 4'b0001),
            {18'h0_0123, 18'h3_fffb, 18'h0_0123, 18'h3_fffb},
            {18'h2_0000, 18'h1_ffff, 18'h1_ffff, 18'h2_0000}, e, FULL, "complex 18");
        e = '0;
        for (int k = 0; k < 4; k++) begin
            e = e | (ext(un(A0, B0, 9, k, 1'b1, ~k[0]), 36, 1'b0) << (36 * k));
        end
        one(mk(mas_pkg::MAS_ADD2, mas_pkg::MAS_W9, 1'b1, 4'b0101), A0, B0, e, FULL,
            "two complex 9");
        $display("two-product adder test done");
    endtask

    task automatic t_add4();
        mas_pkg::mas_cfg_t c;
        logic [143:0] e;
        c = mk(mas_pkg::MAS_ADD4, mas_pkg::MAS_W18, 1'b1, 4'b0000);
        c.casc_en = 1'b1;
        casc_in <= 38'h3f_ffff_fff0;
        e = un(A0, B0, 18, 0, 1'b1, 1'b0) + un(A0, B0, 18, 1, 1'b1, 1'b0) - 144'h10;
        one(c, A0, B0, e, M72, "four sum 18 cascaded");
        chk(casc_out, e[37:0], "cascade out");
        e = un(A0, B0, 9, 0, 1'b1, 1'b0) + un(A0, B0, 9, 1, 1'b1, 1'b1);
        e = (e & M72) | ((un(A0, B0, 9, 2, 1'b1, 1'b0) + un(A0, B0, 9, 3, 1'b1, 1'b0)) << 72);
        one(mk(mas_pkg::MAS_ADD4, mas_pkg::MAS_W9, 1'b1, 4'b0010), A0, B0, e, FULL,
            "two four sums 9");
        $display("four-product adder test done");
    endtask

    // Four-tap filter: samples walk the data chain with coefficients held, then coefficients shift in serially
    task automatic t_fir();
        logic [71:0] am;
        logic [71:0] bm;
        mas_pkg::mas_cfg_t c;
        c = mk(mas_pkg::MAS_ADD4, mas_pkg::MAS_W18, 1'b1, 4'h0);
        am = '0;
        bm = B0;
        one(c, am, bm, 144'h0, M72, "filter load");
        shift_a <= 1'b1;
        coef_hold <= 1'b1;
        for (int n = 0; n < 6; n++) begin
            scan_a_in <= 18'(n * 4099 + 77);
            am = {am[53:0], 18'(n * 4099 + 77)};
            one(c, A1, A1, un(am, bm, 18, 0, 1'b1, 1'b0) + un(am, bm, 18, 1, 1'b1, 1'b0), M72,
                "filter tap sum");
            chk(scan_a_out, am[71:54], "data chain out");
        end
        coef_hold <= 1'b0;
        coef_serial <= 1'b1;
        shift_a <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            scan_b_in <= 18'(n * 911 + 3);
            bm = {bm[53:0], 18'(n * 911 + 3)};
            one(c, am, A1, un(am, bm, 18, 0, 1'b1, 1'b0) + un(am, bm, 18, 1, 1'b1, 1'b0), M72,
                "serial coefficient sum");
            chk(scan_b_out, bm[71:54], "coefficient chain out");
        end
        coef_serial <= 1'b0;
        $display("filter chain test done");
    endtask

    task automatic t_mac();
        mas_pkg::mas_cfg_t c;
        logic [143:0] a0;
        logic [143:0] a1;
        c = mk(mas_pkg::MAS_MAC, mas_pkg::MAS_W18, 1'b1, 4'h0);
        c.acc_clr = 1'b1;
        a0 = mul(A0, B0, 18, 0, 1'b1);
        a1 = mul(A0, B0, 18, 2, 1'b1);
        one(c, A0, B0, ext(a1, 52, 1'b0) << 52 | ext(a0, 52, 1'b0), M72 | M72 << 32,
            "accumulator restart");
        c.acc_clr = 1'b0;
        c.acc_sub = 2'b10;
        a0 = a0 + mul(A1, B0, 18, 0, 1'b1);
        a1 = a1 - mul(A1, B0, 18, 2, 1'b1);
        one(c, A1, B0, ext(a1, 52, 1'b0) << 52 | ext(a0, 52, 1'b0), M72 | M72 << 32,
            "accumulate and subtract");
        // Fabric must build these stages itself at 36 bits
        for (int m = 1; m < 4; m++) begin
            send(mk(mas_pkg::mas_mode_t'(m), mas_pkg::MAS_W36, 1'b1, 4'h0), A0, B0);
            get_chk(mk(mas_pkg::mas_mode_t'(m), mas_pkg::MAS_W36, 1'b1, 4'h0), 1'b1, '0, FULL,
                "no adder at 36 bits");
        end
        send(mk(mas_pkg::MAS_MULT, mas_pkg::MAS_WBAD, 1'b0, 4'h0), A0, B0);
        get_chk(mk(mas_pkg::MAS_MULT, mas_pkg::MAS_WBAD, 1'b0, 4'h0), 1'b1, '0, FULL,
            "undefined width refused");
        c.acc_sub = 2'b00;
        a0 = a0 + mul(A0, B0, 18, 0, 1'b1);
        a1 = a1 + mul(A0, B0, 18, 2, 1'b1);
        one(c, A0, B0, ext(a1, 52, 1'b0) << 52 | ext(a0, 52, 1'b0), M72 | M72 << 32,
            "accumulators untouched by refusal");
        c = mk(mas_pkg::MAS_MAC, mas_pkg::MAS_W9, 1'b0, 4'h0);
        c.acc_clr = 1'b1;
        one(c, A0, B0, ext(mul(A0, B0, 9, 4, 1'b0), 52, 1'b0) << 52 | mul(A0, B0, 9, 0, 1'b0),
            M72 | M72 << 32, "nine-bit accumulators");
        $display("accumulate test done");
    endtask

    task automatic t_fifo();
        int k;
        stall <= 1'b1;
        repeat (2) @(posedge clk);
        k = 0;
        cfg <= mk(mas_pkg::MAS_MULT, mas_pkg::MAS_W18, 1'b0, 4'h0);
        b_in <= 72'h1;
        a_in <= 72'h0;
        in_valid <= 1'b1;
        @(negedge clk);
        while (in_ready === 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
            a_in <= 72'(k);
            @(negedge clk);
        end
        @(posedge clk);
        in_valid <= 1'b0;
        chk(k, mas_pkg::FIFO_DEPTH + 1, "words held while stalled");
        @(negedge clk);
        chk(in_ready, 1'b0, "intake closed when full");
        @(posedge clk);
        stall <= 1'b0;
        for (int j = 0; j < mas_pkg::FIFO_DEPTH + 1; j++) begin
            get_chk(mk(mas_pkg::MAS_MULT, mas_pkg::MAS_W18, 1'b0, 4'h0), 1'b0, 144'(j), FULL,
                "drain order");
        end
        // Empty pipe here, so only the enable can close the intake
        ena <= 1'b0;
        @(negedge clk);
        chk(in_ready, 1'b0, "intake frozen by enable");
        @(posedge clk);
        ena <= 1'b1;
        $display("buffer test done");
    endtask

    // Mid-run reset with results queued and chains loaded
    task automatic t_reset();
        stall <= 1'b1;
        send(mk(mas_pkg::MAS_MULT, mas_pkg::MAS_W9, 1'b0, 4'h0), A0, B0);
        in_valid <= 1'b0;
        repeat (3) @(posedge clk);
        chk(out_valid, 1'b1, "result waiting");
        rst_n <= 1'b0;
        @(negedge clk);
        chk({out_valid, in_ready, scan_a_out, scan_b_out, casc_out}, {2'b01, 74'h0},
            "outputs in reset");
        @(posedge clk);
        rst_n <= 1'b1;
        stall <= 1'b0;
        one(mk(mas_pkg::MAS_MULT, mas_pkg::MAS_W36, 1'b0, 4'h0), A1, B0,
            mul(A1, B0, 36, 0, 1'b0), M72, "first word after reset");
        $display("reset test done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_mult();
        t_add2();
        t_add4();
        t_fir();
        t_mac();
        t_fifo();
        t_reset();
        results();
    end
endmodule
